//--- hw/ipt_defines.svh
`ifndef IPT_DEFINES_SVH
`define IPT_DEFINES_SVH

`define IPT_WORD_W        16
`define IPT_ADV_W         2
`define IPT_WORD_RST      16'h0000
`define IPT_ADV_NONE      2'h3
`define IPT_ADV_BOTH      2'h0
`define IPT_ADV_STAGE_B   2'h2
`define IPT_ADV_STAGE_C   2'h1
`define IPT_FLUSH_CYCLES  2'h2
`define IPT_HOLD_LAST     2'h1
`define IPT_HOLD_NONE     2'h0

`endif

//--- hw/ipt_pkg.sv
package ipt_pkg;
    `include "ipt_defines.svh"

    typedef enum logic [2:0] {
        IPT_IND_IDLE  = 3'b001,
        IPT_IND_FETCH = 3'b010,
        IPT_IND_FLUSH = 3'b100
    } ipt_ind_state_t;

    typedef logic [`IPT_WORD_W-1:0] ipt_word_t;
endpackage

//--- hw/ipt_instruction_pipe.sv
`timescale 1ns/1ps
`include "ipt_defines.svh"

module ipt_instruction_pipe
    import ipt_pkg::*;
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_fetch,
    input  wire logic                   i_fetch_long,
    input  wire logic                   i_flush,
    input  wire logic                   i_supervisor,
    input  wire logic [2*`IPT_WORD_W-1:0] i_bus_data,
    input  wire logic                   i_consume_c,
    output logic                        o_fetch_indicator_n,
    output logic [`IPT_ADV_W-1:0]       o_pipe_advance_code,
    output logic [`IPT_WORD_W-1:0]      o_immediate_data,
    output logic [`IPT_WORD_W-1:0]      o_residual_opcode,
    output logic                        o_stage_b_valid,
    output logic                        o_stage_c_valid,
    output logic                        o_pipe_ready
);

    ipt_ind_state_t state_ff, nxt_state;
    logic [1:0]     hold_ff, nxt_hold;
    logic           ind_n_ff, nxt_ind_n;
    ipt_word_t      prefetch_primary_reg_ff, nxt_prefetch_primary_reg;
    ipt_word_t      prefetch_secondary_reg_ff, nxt_prefetch_secondary_reg;
    ipt_word_t      initial_decode_reg_ff, nxt_initial_decode_reg;
    ipt_word_t      residual_decode_reg_ff, nxt_residual_decode_reg;
    logic           a_vld_ff, nxt_a_vld;
    logic           l_vld_ff, nxt_l_vld;
    logic           b_vld_ff, nxt_b_vld;
    logic           c_vld_ff, nxt_c_vld;
    logic [`IPT_ADV_W-1:0] adv_ff, nxt_adv;
    logic           adv_b;
    logic           adv_c;
    logic           take;

    function automatic logic [`IPT_ADV_W-1:0] adv_encode(input logic b, input logic c);
        logic [`IPT_ADV_W-1:0] code;
        code = `IPT_ADV_NONE;
        if (b && c) begin
            code = `IPT_ADV_BOTH;
        end else if (b) begin
            code = `IPT_ADV_STAGE_B;
        end else if (c) begin
            code = `IPT_ADV_STAGE_C;
        end
        return code;
    endfunction

    // fetch accepted when the buffer stage can take a whole fetch, or at any time with a flush
    // limitation: a taken fetch blocks the next edge, so plain fetches land at most every other cycle
    assign o_pipe_ready = i_flush || (!a_vld_ff && !l_vld_ff);
    assign take = i_fetch && o_pipe_ready && (i_supervisor || !i_supervisor);

    // indicator sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_hold  = hold_ff;
        nxt_ind_n = 1'b1;
        if (take && i_flush) begin
            nxt_state = IPT_IND_FLUSH;
            nxt_hold  = `IPT_FLUSH_CYCLES - `IPT_HOLD_LAST;
            nxt_ind_n = 1'b0;
        end else begin
            unique case (state_ff)
                IPT_IND_FLUSH: begin
                    nxt_ind_n = 1'b0;
                    // chained fetch extends low to three
                    // a plain take cannot land in the first flush cycle: stage A is still full
                    if (hold_ff == `IPT_HOLD_LAST) begin
                        nxt_hold  = `IPT_HOLD_NONE;
                        nxt_state = take ? IPT_IND_FETCH : IPT_IND_IDLE;
                    end else begin
                        nxt_state = IPT_IND_IDLE;
                        nxt_ind_n = !take;
                        if (take) begin
                            nxt_state = IPT_IND_FETCH;
                        end
                    end
                end
                IPT_IND_IDLE, IPT_IND_FETCH: begin
                    nxt_ind_n = !take;
                    nxt_state = take ? IPT_IND_FETCH : IPT_IND_IDLE;
                end
                default: begin
                    // illegal code: recover as if idle, never stick low
                    nxt_ind_n = !take;
                    nxt_state = take ? IPT_IND_FETCH : IPT_IND_IDLE;
                end
            endcase
        end
    end

    // queue
    always_comb begin
        nxt_prefetch_primary_reg   = prefetch_primary_reg_ff;
        nxt_prefetch_secondary_reg = prefetch_secondary_reg_ff;
        nxt_initial_decode_reg     = initial_decode_reg_ff;
        nxt_residual_decode_reg    = residual_decode_reg_ff;
        nxt_a_vld = a_vld_ff;
        nxt_l_vld = l_vld_ff;
        nxt_b_vld = b_vld_ff;
        nxt_c_vld = c_vld_ff;
        adv_b = 1'b0;
        adv_c = 1'b0;
        // consume from third stage, refill from second
        if (c_vld_ff && i_consume_c) begin
            nxt_c_vld = 1'b0;
        end
        if (b_vld_ff && (!c_vld_ff || i_consume_c)) begin
            nxt_residual_decode_reg = initial_decode_reg_ff;
            nxt_c_vld = 1'b1;
            nxt_b_vld = 1'b0;
            adv_c     = 1'b1;
        end
        if (!nxt_b_vld) begin
            if (a_vld_ff) begin
                nxt_initial_decode_reg = prefetch_primary_reg_ff;
                nxt_b_vld = 1'b1;
                nxt_a_vld = 1'b0;
                adv_b     = 1'b1;
            end else if (l_vld_ff) begin
                nxt_initial_decode_reg = prefetch_secondary_reg_ff;
                nxt_b_vld = 1'b1;
                nxt_l_vld = 1'b0;
                adv_b     = 1'b1;
            end
        end
        // flush wins over any move this cycle: stale words must not advance
        if (take && i_flush) begin
            nxt_b_vld = 1'b0;
            nxt_c_vld = 1'b0;
            nxt_l_vld = 1'b0;
            adv_b     = 1'b0;
            adv_c     = 1'b0;
        end
        // primary every fetch, secondary only long
        if (take) begin
            nxt_prefetch_primary_reg = i_bus_data[2*`IPT_WORD_W-1:`IPT_WORD_W];
            nxt_a_vld = 1'b1;
            if (i_fetch_long) begin
                nxt_prefetch_secondary_reg = i_bus_data[`IPT_WORD_W-1:0];
                nxt_l_vld = 1'b1;
            end
        end
    end

    // advance reported each cycle
    // registered with the stage valids so the code and the load line up
    assign nxt_adv = adv_encode(adv_b, adv_c);

    // indicator group: only registers the sequencer's next values
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_ff <= IPT_IND_IDLE;
            hold_ff  <= `IPT_HOLD_NONE;
            ind_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            hold_ff  <= nxt_hold;
            ind_n_ff <= nxt_ind_n;
        end
    end

    // queue group: storage, valids and the advance report
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            prefetch_primary_reg_ff   <= `IPT_WORD_RST;
            prefetch_secondary_reg_ff <= `IPT_WORD_RST;
            initial_decode_reg_ff     <= `IPT_WORD_RST;
            residual_decode_reg_ff    <= `IPT_WORD_RST;
            a_vld_ff                  <= 1'b0;
            l_vld_ff                  <= 1'b0;
            b_vld_ff                  <= 1'b0;
            c_vld_ff                  <= 1'b0;
            adv_ff                    <= `IPT_ADV_NONE;
        end else begin
            prefetch_primary_reg_ff   <= nxt_prefetch_primary_reg;
            prefetch_secondary_reg_ff <= nxt_prefetch_secondary_reg;
            initial_decode_reg_ff     <= nxt_initial_decode_reg;
            residual_decode_reg_ff    <= nxt_residual_decode_reg;
            a_vld_ff                  <= nxt_a_vld;
            l_vld_ff                  <= nxt_l_vld;
            b_vld_ff                  <= nxt_b_vld;
            c_vld_ff                  <= nxt_c_vld;
            adv_ff                    <= nxt_adv;
        end
    end

    assign o_fetch_indicator_n = ind_n_ff;
    assign o_pipe_advance_code = adv_ff;
    assign o_immediate_data    = initial_decode_reg_ff;
    assign o_residual_opcode   = residual_decode_reg_ff;
    assign o_stage_b_valid     = b_vld_ff;
    assign o_stage_c_valid     = c_vld_ff;

endmodule

//--- testbench/ipt_pipe_chk.sv
`timescale 1ns/1ps
module ipt_pipe_chk (
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    input wire logic        i_fetch,
    input wire logic        i_flush,
    input wire logic        o_fetch_indicator_n,
    input wire logic [1:0]  o_pipe_advance_code,
    input wire logic [15:0] o_immediate_data,
    input wire logic [15:0] o_residual_opcode,
    input wire logic        o_stage_b_valid,
    input wire logic        o_stage_c_valid,
    input wire logic        o_pipe_ready
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    a_fetch_pulse_low: assert property (i_fetch && o_pipe_ready |=> !o_fetch_indicator_n)
        else $error("taken fetch gave no low indicator");
    a_idle_stays_high: assert property (!(i_fetch && o_pipe_ready) && !$past(i_fetch && i_flush)
        |=> o_fetch_indicator_n) else $error("indicator low without fetch");
    a_flush_two_low: assert property (i_fetch && i_flush |=> !o_fetch_indicator_n [*2])
        else $error("flush indicator not two cycles low");
    a_flush_clears_stages: assert property (i_fetch && i_flush |=> !o_stage_b_valid && !o_stage_c_valid)
        else $error("flush left stages valid");
    a_flush_always_ready: assert property (i_flush |-> o_pipe_ready)
        else $error("flush not accepted");
    a_adv_stage_b: assert property ($rose(o_stage_b_valid) |-> !o_pipe_advance_code[0])
        else $error("second stage load not reported");
    a_adv_stage_c: assert property ($rose(o_stage_c_valid) |-> !o_pipe_advance_code[1])
        else $error("third stage load not reported");
    a_c_from_b: assert property ($rose(o_stage_c_valid) |-> $past(o_stage_b_valid)
        && o_residual_opcode == $past(o_immediate_data)) else $error("third stage not fed by second");
    a_code_has_stage: assert property (o_pipe_advance_code != 2'h3 |-> o_stage_b_valid || o_stage_c_valid)
        else $error("advance code without a loaded stage");
endmodule

//--- testbench/ipt_track_model.sv
`timescale 1ns/1ps
module ipt_track_model (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_fetch_indicator_n,
    output logic             o_done,
    output logic [15:0]      o_run_len
);
    logic [15:0] cnt_ff;
    // sample each rising edge; run width tells fetch from flush
    always @(posedge i_mclk) begin
        o_done <= 1'h0;
        if (!i_rst_n) begin
            cnt_ff <= 16'h0000;
        end else if (!i_fetch_indicator_n) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end else if (cnt_ff != 16'h0000) begin
            o_done <= 1'h1;
            o_run_len <= cnt_ff;
            cnt_ff <= 16'h0000;
        end
    end
endmodule

//--- testbench/ipt_instruction_pipe_tb.sv
`timescale 1ns/1ps
module ipt_instruction_pipe_tb;
    import ipt_pkg::*;
    logic        i_mclk, i_rst_n, i_fetch, i_fetch_long, i_flush, i_supervisor, i_consume_c;
    logic [31:0] i_bus_data;
    logic        o_fetch_indicator_n, o_pipe_ready, trk_done;
    logic [1:0]  o_pipe_advance_code;
    ipt_word_t   o_immediate_data;
    ipt_word_t   o_residual_opcode, exp_w;
    logic [15:0] trk_len;
    integer      num_errors = 0;
    integer      n_tests = 0;
    integer      seed = 32'h1a06_7181;
    ipt_word_t   imm_q[$];
    ipt_word_t   res_q[$];
    logic [15:0] wid_q[$];
    ipt_instruction_pipe u_dut (.i_mclk, .i_rst_n, .i_fetch, .i_fetch_long, .i_flush, .i_supervisor,
        .i_bus_data, .i_consume_c, .o_fetch_indicator_n, .o_pipe_advance_code, .o_immediate_data,
        .o_residual_opcode, .o_stage_b_valid(), .o_stage_c_valid(), .o_pipe_ready);
    ipt_track_model u_trk (.i_mclk, .i_rst_n, .i_fetch_indicator_n(o_fetch_indicator_n),
        .o_done(trk_done), .o_run_len(trk_len));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic step(input int k);
        @(negedge i_mclk);
        if (k > 200) begin
            num_errors++;
            final_report();
        end
    endtask
    // a flush only once every earlier word has reached the second stage
    task automatic go(input logic lng, input logic fl, input logic [15:0] w);
        int k;
        for (k = 0; fl && imm_q.size() != 0; k++) step(k);
        @(posedge i_mclk);
        i_fetch <= 1'h1;
        i_fetch_long <= lng;
        i_flush <= fl;
        i_supervisor <= 1'($random(seed));
        i_bus_data <= $random(seed);
        for (k = 0; k == 0 || !o_pipe_ready; k++) step(k);
        @(posedge i_mclk);
        if (w != 16'h0000) wid_q.push_back(w);
        imm_q.push_back(i_bus_data[31:16]);
        if (lng) imm_q.push_back(i_bus_data[15:0]);
        i_fetch <= 1'h0;
    endtask
    always @(posedge i_mclk) begin
        i_consume_c <= 1'($random(seed));
        // third-stage load checked before the second-stage pop refills the note queue
        if (i_rst_n && o_pipe_advance_code[1] === 1'h0)
            chk("residual", res_q.size() ? res_q.pop_front() : 16'hxxxx, o_residual_opcode);
        if (i_rst_n && o_pipe_advance_code[0] === 1'h0) begin
            exp_w = imm_q.size() ? imm_q.pop_front() : 16'hxxxx;
            res_q.push_back(exp_w);
            chk("immediate", exp_w, o_immediate_data);
        end
        // a taken flush discards whatever waits in the second stage
        if (i_rst_n && i_fetch && i_flush && o_pipe_ready)
            res_q.delete();
        if (trk_done)
            chk("indicator width", wid_q.size() ? wid_q.pop_front() : 16'h0000, trk_len);
    end
    initial begin
        i_mclk = 1'h0;
        forever #20 i_mclk = ~i_mclk;
    end
    initial begin
        {i_rst_n, i_fetch, i_fetch_long, i_flush, i_supervisor, i_consume_c, i_bus_data} = '0;
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'h1;
        repeat (30) go(1'($random(seed)), 1'h0, 16'h0001);
        $display("fetch test done");
        repeat (4) begin
            go(1'($random(seed)), 1'h1, 16'h0002);
            @(posedge i_mclk);
        end
        $display("flush test done");
        go(1'h0, 1'h1, 16'h0000);
        go(1'h1, 1'h0, 16'h0003);
        repeat (60) @(posedge i_mclk);
        $display("flush fetch test done");
        chk("pending", 16'h0000, 16'(wid_q.size() + imm_q.size() + res_q.size()));
        final_report();
    end
endmodule
bind ipt_instruction_pipe ipt_pipe_chk u_chk (.i_mclk, .i_rst_n, .i_fetch, .i_flush, .o_fetch_indicator_n,
    .o_pipe_advance_code, .o_immediate_data, .o_residual_opcode, .o_stage_b_valid, .o_stage_c_valid, .o_pipe_ready);
